//--- logic/imbc_regs.svh
`ifndef IMBC_REGS_SVH
`define IMBC_REGS_SVH

// Outcome codes
`define IMBC_OUT_OK       3'h0
`define IMBC_OUT_BUSY     3'h1
`define IMBC_OUT_NOTOWN   3'h2
`define IMBC_OUT_NAK      3'h3
`define IMBC_OUT_ARB      3'h4
`define IMBC_OUT_ABORT    3'h5
// Command codes
`define IMBC_CMD_START    3'h1
`define IMBC_CMD_RESTART  3'h2
`define IMBC_CMD_STOP     3'h3
`define IMBC_CMD_WRITE    3'h4
`define IMBC_CMD_READ     3'h5
`define IMBC_CMD_CLR_RD   3'h6
`define IMBC_CMD_CLR_WR   3'h7
// Timing: quarter of an SCL bit at 100 kbps, in ns
`define IMBC_QTR_NS       2500
`define IMBC_CLK_NS       50
`define IMBC_QTR_CYC      ((`IMBC_QTR_NS) / (`IMBC_CLK_NS))
// Reset values
`define IMBC_CNT_RST      8'h00
`define IMBC_BYTE_RST     8'h00

`endif

//--- logic/imbc_pkg.sv
package imbc_pkg;

    typedef logic [2:0] imbc_cmd_t;
    typedef logic [2:0] imbc_outcome_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START,
        ST_BIT,
        ST_ACK,
        ST_RACK,
        ST_STOP,
        ST_DONE
    } imbc_state_t;

endpackage : imbc_pkg

//--- logic/imbc_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for the bus pins; only stage two is read outside
module imbc_sync (
    // Clock
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic       i_ce,
    // Pins
    input  wire logic [1:0] i_async,
    output logic      [1:0] o_sync
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;

    // Both stages freeze with the clock enable; reset to idle bus level
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : imbc_sync

//--- logic/imbc_master.sv
`timescale 1ns/1ps
`include "imbc_regs.svh"
// Behaviour
// - Start, then 7-bit address and direction
// - Direction zero writes, nonzero reads
// - Occupied bus: no Start, busy outcome
// - Not owner or slave busy: refuse
// - NAK on last byte reported
// - Arbitration loss only with multi-master
// - Slave activity first aborts Start
// - Every command but the two clears and code 0 sets byte-done flag
// - Repeated Start without Stop, then address
// - Stop does nothing after failed Start
// - Stop ends on Stop or lost arbitration
// - Write sends one byte after good Start
// - Write idle after failed Start
// - Read byte then ACK per select
// - Read after failed Start returns zero
// - Counters show bytes moved so far
// - Clear-read resets read pointer
// - Clear-write resets write pointer
// - Slave and multi-master coexist in block
module imbc_master (
    // Clock and control
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire logic                  i_ce,
    // Configuration
    input  wire logic                  i_multi_master,
    input  wire logic                  i_slave_enable,
    input  wire logic                  i_slave_active,
    // Command port
    input  wire logic                  i_cmd_valid,
    input  wire imbc_pkg::imbc_cmd_t   i_cmd,
    input  wire logic [6:0]            i_address,
    input  wire logic [7:0]            i_direction_select,
    input  wire logic [7:0]            i_ack_select,
    input  wire logic [7:0]            i_wdata,
    // Status
    output logic                       o_byte_done,
    output logic                       o_busy,
    output imbc_pkg::imbc_outcome_t    o_outcome,
    output logic [7:0]                 o_rdata,
    output logic [7:0]                 o_rd_count,
    output logic [7:0]                 o_wr_count,
    // Bus pins, open drain
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_scl_oe,
    output logic                       o_sda_oe
);
    import imbc_pkg::*;

    localparam logic [7:0] QTR = 8'(`IMBC_QTR_CYC);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        imbc_state_t   st;
        logic [7:0]    tmr;
        logic [1:0]    ph;
        logic [3:0]    bitn;
        logic [7:0]    sh;
        logic          rd;
        logic          is_stop;
        logic          ack_bit;
        logic          owner;
        logic          good;
        logic          bus_busy;
        logic [1:0]    prev;
        logic          done;
        logic          busy;
        imbc_outcome_t outcome;
        logic [7:0]    rdata;
        logic [7:0]    rcnt;
        logic [7:0]    wcnt;
        logic          scl_oe;
        logic          sda_oe;
    } imbc_st_t;

    imbc_st_t s_q;
    imbc_st_t s_d;
    logic [1:0] pins;
    logic       scl_s;
    logic       sda_s;
    logic       tick;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    imbc_sync u_sync (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_ce    (i_ce),
        .i_async ({i_scl, i_sda}),
        .o_sync  (pins)
    );

    assign scl_s = pins[1];
    assign sda_s = pins[0];
    assign tick  = (s_q.tmr == 8'h00);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.prev = {scl_s, sda_s};
        // Bus occupancy from Start/Stop seen by anyone, including us
        if (s_q.prev[1] && scl_s && s_q.prev[0] && !sda_s) begin
            s_d.bus_busy = 1'b1;
        end else if (s_q.prev[1] && scl_s && !s_q.prev[0] && sda_s) begin
            s_d.bus_busy = 1'b0;
        end
        if (s_q.tmr != 8'h00) begin
            s_d.tmr = s_q.tmr - 8'h01;
        end

        unique case (s_q.st)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    s_d.busy = 1'b1;
                    s_d.outcome = `IMBC_OUT_OK;
                    s_d.tmr = QTR;
                    s_d.ph = 2'h0;
                    s_d.is_stop = 1'b0;
                    unique case (i_cmd)
                        `IMBC_CMD_START, `IMBC_CMD_RESTART: begin
                            s_d.sh = {i_address, (i_direction_select != 8'h00)};
                            s_d.rd = (i_direction_select != 8'h00);
                            s_d.bitn = 4'h0;
                            if (i_slave_active) begin
                                s_d.outcome = `IMBC_OUT_NOTOWN;
                                s_d.st = ST_DONE;
                            end else if (i_cmd == `IMBC_CMD_START && s_q.bus_busy) begin
                                s_d.outcome = `IMBC_OUT_BUSY;
                                s_d.st = ST_DONE;
                            end else if (i_cmd == `IMBC_CMD_RESTART && !s_q.owner) begin
                                s_d.outcome = `IMBC_OUT_NOTOWN;
                                s_d.st = ST_DONE;
                            end else begin
                                s_d.good = 1'b0;
                                s_d.st = ST_START;
                            end
                        end
                        `IMBC_CMD_STOP: begin
                            s_d.is_stop = 1'b1;
                            if (s_q.good && s_q.owner) begin
                                s_d.st = ST_STOP;
                            end else begin
                                s_d.st = ST_DONE;
                            end
                        end
                        `IMBC_CMD_WRITE, `IMBC_CMD_READ: begin
                            s_d.rd = (i_cmd == `IMBC_CMD_READ);
                            s_d.sh = (i_cmd == `IMBC_CMD_READ) ? 8'hFF : i_wdata;
                            s_d.ack_bit = (i_ack_select == 8'h00);
                            s_d.bitn = 4'h0;
                            if (!s_q.good || !s_q.owner) begin
                                if (i_cmd == `IMBC_CMD_READ) begin
                                    s_d.rdata = `IMBC_BYTE_RST;
                                end else begin
                                    s_d.outcome = `IMBC_OUT_NOTOWN;
                                end
                                s_d.st = ST_DONE;
                            end else begin
                                s_d.st = ST_BIT;
                            end
                        end
                        `IMBC_CMD_CLR_RD: begin
                            s_d.rcnt = `IMBC_CNT_RST;
                            s_d.busy = 1'b0;
                        end
                        `IMBC_CMD_CLR_WR: begin
                            s_d.wcnt = `IMBC_CNT_RST;
                            s_d.busy = 1'b0;
                        end
                        default: begin
                            s_d.busy = 1'b0;
                        end
                    endcase
                end
            end
            // Start or repeated Start: release both, then SDA low under SCL high
            ST_START: if (tick) begin
                s_d.tmr = QTR;
                s_d.ph = s_q.ph + 2'h1;
                unique case (s_q.ph)
                    2'h0: begin s_d.sda_oe = 1'b0; s_d.scl_oe = 1'b0; end
                    2'h1: begin
                        if (i_slave_enable && i_slave_active) begin
                            s_d.outcome = `IMBC_OUT_ABORT;
                            s_d.st = ST_DONE;
                        end else if (i_multi_master && !sda_s) begin
                            s_d.outcome = `IMBC_OUT_ARB;
                            s_d.owner = 1'b0;
                            s_d.st = ST_DONE;
                        end else begin
                            s_d.sda_oe = 1'b1;
                        end
                    end
                    2'h2: s_d.scl_oe = 1'b1;
                    2'h3: begin s_d.owner = 1'b1; s_d.ph = 2'h0; s_d.st = ST_BIT; end
                endcase
            end
            // Eight data bits: drive on phase 0, SCL high on 1, sample on 2
            ST_BIT: if (tick) begin
                s_d.tmr = QTR;
                s_d.ph = s_q.ph + 2'h1;
                unique case (s_q.ph)
                    2'h0: s_d.sda_oe = ~s_q.sh[7];
                    2'h1: s_d.scl_oe = 1'b0;
                    2'h2: begin
                        // Stretched clock: hold phase until SCL really rises
                        if (!scl_s) begin
                            s_d.ph = s_q.ph;
                        end else if (i_multi_master && s_q.sh[7] && !sda_s
                                     && !(s_q.rd && s_q.good)) begin   // Read data is not ours
                            s_d.outcome = `IMBC_OUT_ARB;
                            s_d.owner = 1'b0;
                            s_d.sda_oe = 1'b0;
                            s_d.st = ST_DONE;
                        end else begin
                            s_d.sh = {s_q.sh[6:0], sda_s};
                        end
                    end
                    2'h3: begin
                        s_d.scl_oe = 1'b1;
                        s_d.ph = 2'h0;
                        s_d.bitn = s_q.bitn + 4'h1;
                        if (s_q.bitn == 4'h7) begin
                            s_d.st = (s_q.rd && s_q.good) ? ST_RACK : ST_ACK;
                        end
                    end
                endcase
            end
            // Acknowledge from slave after address or written byte
            ST_ACK: if (tick) begin
                s_d.tmr = QTR;
                s_d.ph = s_q.ph + 2'h1;
                unique case (s_q.ph)
                    2'h0: s_d.sda_oe = 1'b0;
                    2'h1: s_d.scl_oe = 1'b0;
                    2'h2: begin
                        if (!scl_s) begin
                            s_d.ph = s_q.ph;
                        end else if (sda_s) begin
                            s_d.outcome = `IMBC_OUT_NAK;
                        end
                    end
                    2'h3: begin
                        s_d.scl_oe = 1'b1;
                        if (s_q.good) begin
                            s_d.wcnt = s_q.wcnt + 8'h01;
                        end
                        s_d.good = 1'b1;
                        s_d.st = ST_DONE;
                    end
                endcase
            end
            // Master answers a read byte with ACK or NAK
            ST_RACK: if (tick) begin
                s_d.tmr = QTR;
                s_d.ph = s_q.ph + 2'h1;
                unique case (s_q.ph)
                    2'h0: begin
                        s_d.sda_oe = ~s_q.ack_bit;
                        s_d.rdata = s_q.sh;
                    end
                    2'h1: s_d.scl_oe = 1'b0;
                    2'h2: if (!scl_s) s_d.ph = s_q.ph;
                    2'h3: begin
                        s_d.scl_oe = 1'b1;
                        s_d.sda_oe = 1'b0;
                        s_d.rcnt = s_q.rcnt + 8'h01;
                        s_d.st = ST_DONE;
                    end
                endcase
            end
            // Stop: SDA low, SCL released, then SDA released
            ST_STOP: if (tick) begin
                s_d.tmr = QTR;
                s_d.ph = s_q.ph + 2'h1;
                unique case (s_q.ph)
                    2'h0: s_d.sda_oe = 1'b1;
                    2'h1: s_d.scl_oe = 1'b0;
                    2'h2: begin
                        if (!scl_s) begin
                            s_d.ph = s_q.ph;
                        end else if (i_multi_master && sda_s) begin
                            // Someone else held the line on the last ACK
                            s_d.outcome = `IMBC_OUT_ARB;
                            s_d.sda_oe = 1'b0;
                            s_d.owner = 1'b0;
                            s_d.st = ST_DONE;
                        end else begin
                            s_d.sda_oe = 1'b0;
                        end
                    end
                    2'h3: begin s_d.owner = 1'b0; s_d.st = ST_DONE; end
                endcase
            end
            // Completion: one-cycle flag, distinct outcome code held
            ST_DONE: begin
                s_d.done = 1'b1;
                s_d.busy = 1'b0;
                s_d.ph = 2'h0;
                // A NAK keeps the Start valid, else a Stop could never free a held SCL
                if (s_q.is_stop || (s_q.outcome != `IMBC_OUT_OK
                                    && s_q.outcome != `IMBC_OUT_NAK)) begin
                    s_d.good = 1'b0;
                end
                if (s_q.outcome == `IMBC_OUT_ARB || s_q.outcome == `IMBC_OUT_ABORT) begin
                    s_d.good = 1'b0;
                end
                s_d.st = ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // ************************************************************
    // Register
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.prev <= 2'h3;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_byte_done = s_q.done;
    assign o_busy      = s_q.busy;
    assign o_outcome   = s_q.outcome;
    assign o_rdata     = s_q.rdata;
    assign o_rd_count  = s_q.rcnt;
    assign o_wr_count  = s_q.wcnt;
    assign o_scl_oe    = s_q.scl_oe;
    assign o_sda_oe    = s_q.sda_oe;
endmodule : imbc_master

//--- verification/imbc_master_assertions.sv
`timescale 1ns/1ps
`include "imbc_regs.svh"
// ************************************************************
// Port-level checks on the byte command engine
// ************************************************************
module imbc_master_assertions
    import imbc_pkg::*;
(
    // Clock and configuration
    input  wire logic                    i_clk,
    input  wire logic                    i_srst,
    input  wire logic                    i_ce,
    input  wire logic                    i_multi_master,
    input  wire logic                    i_slave_enable,
    input  wire logic                    i_slave_active,
    // Command port
    input  wire logic                    i_cmd_valid,
    input  wire imbc_pkg::imbc_cmd_t     i_cmd,
    // Status and pins
    input  wire logic                    o_byte_done,
    input  wire logic                    o_busy,
    input  wire imbc_pkg::imbc_outcome_t o_outcome,
    input  wire logic [7:0]              o_rd_count,
    input  wire logic [7:0]              o_wr_count,
    input  wire logic                    o_scl_oe,
    input  wire logic                    o_sda_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic tk;
    // A command is taken only while the engine is idle
    assign tk = i_ce && i_cmd_valid && !o_busy;
    sequence s_refused;
        ##[1:3] (o_byte_done && o_outcome == `IMBC_OUT_NOTOWN);
    endsequence
    sequence s_quiet;
        (!o_sda_oe && !o_scl_oe) [*2];
    endsequence
    done_pulse_a: assert property (o_byte_done |=> !o_byte_done)
        else $error("done flag wider than one cycle");
    notown_start_a: assert property (tk && i_cmd == `IMBC_CMD_START && i_slave_active |-> s_refused)
        else $error("start with slave busy not refused");
    refuse_quiet_a: assert property (tk && i_cmd == `IMBC_CMD_START && i_slave_active |=> s_quiet)
        else $error("refused start touched the bus");
    no_arb_single_a: assert property (o_byte_done && !i_multi_master |-> o_outcome != `IMBC_OUT_ARB)
        else $error("arbitration loss without multi-master");
    no_abort_a: assert property (o_byte_done && !i_slave_enable |-> o_outcome != `IMBC_OUT_ABORT)
        else $error("start abort outside slave mode");
    outcome_code_a: assert property (o_byte_done |-> o_outcome <= `IMBC_OUT_ABORT)
        else $error("undefined outcome code");
    clr_read_a: assert property (tk && i_cmd == `IMBC_CMD_CLR_RD |=> o_rd_count == 8'h00 && !o_byte_done)
        else $error("read pointer not cleared");
    clr_write_a: assert property (tk && i_cmd == `IMBC_CMD_CLR_WR |=> o_wr_count == 8'h00 && !o_byte_done)
        else $error("write pointer not cleared");
    wr_step_a: assert property ($changed(o_wr_count) && !$past(tk) |-> o_wr_count == $past(o_wr_count) + 8'h01)
        else $error("write count moved by more than one");
endmodule : imbc_master_assertions

bind imbc_master imbc_master_assertions i_chk (.i_clk, .i_srst, .i_ce, .i_multi_master,
    .i_slave_enable, .i_slave_active, .i_cmd_valid, .i_cmd, .o_byte_done, .o_busy,
    .o_outcome, .o_rd_count, .o_wr_count, .o_scl_oe, .o_sda_oe);

//--- verification/imbc_slave_model.sv
`timescale 1ns/1ps
// ************************************************************
// Slave partner on the pulled-up open-drain bus
// ************************************************************
module imbc_slave_model #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    // Bus levels
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    // Scenario controls
    input  wire logic       i_nak,
    input  wire logic       i_stretch,
    input  wire logic       i_grab_sda,
    input  wire logic [7:0] i_tx,
    // Pull-downs and capture
    output logic            o_scl_oe,
    output logic            o_sda_oe,
    output logic [7:0]      o_rx,
    output logic            o_mack
);
    logic [7:0] sh;
    logic       sel = 1'b0;
    logic       first = 1'b0;
    logic       rd = 1'b0;
    logic       drv = 1'b0;
    int         bitn = 0;
    initial o_scl_oe = 1'b0;
    // Grab stands for a rival master pulling the data line
    assign o_sda_oe = drv | i_grab_sda;
    // Start or repeated Start re-arms the framer; Stop drops it
    always @(negedge i_sda) begin
        if (i_scl) begin
            sel = 1'b1;
            first = 1'b1;
            bitn = 0;
        end
    end
    always @(posedge i_sda) begin
        if (i_scl) sel = 1'b0;
    end
    // Sample on rising clock, MSB first; the ninth bit is the acknowledge
    always @(posedge i_scl) begin
        if (sel) begin
            if (bitn < 8) sh = {sh[6:0], i_sda};
            if (bitn == 8 && rd && !first) o_mack = i_sda;
            if (bitn == 8 && ((rd && !first && i_sda) || (first && !drv))) sel = 1'b0;
            if (bitn == 8) first = 1'b0;
            bitn = (bitn + 1) % 9;
        end
    end
    // Change data only while the clock is low, so no false Start or Stop
    always @(negedge i_scl) begin
        if (sel && bitn == 8) begin
            if (first) rd = sh[0];
            if (first || !rd) o_rx = sh;
            drv = (first ? sh[7:1] == ADDR : !rd) && !i_nak;
        end else begin
            drv = sel && rd && !first && !i_tx[7 - bitn];
        end
        if (sel && i_stretch) begin
            o_scl_oe = 1'b1;
            #4000 o_scl_oe = 1'b0;
        end
    end
endmodule : imbc_slave_model

//--- verification/tb_imbc_master.sv
`timescale 1ns/1ps
`include "imbc_regs.svh"
// ************************************************************
// Scenario bench for the byte command engine
// ************************************************************
module tb_imbc_master;
    import imbc_pkg::*;
    localparam logic [6:0] SLV = 7'h2A;
    logic          clk, srst, mm, sen, sact, cv, done, busy, m_scl, m_sda, s_scl, s_sda;
    logic          nak, strt, grab, mack, act;
    imbc_cmd_t     cmd;
    imbc_outcome_t oc;
    logic [6:0]    addr;
    logic [7:0]    dir, acks, wd, rd, rc, wc, tx, rx, base;
    int            mismatches, n_tests, n;
    wire           scl = !(m_scl | s_scl);
    wire           sda = !(m_sda | s_sda);
    imbc_master i_dut (.i_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_multi_master(mm),
        .i_slave_enable(sen), .i_slave_active(sact), .i_cmd_valid(cv), .i_cmd(cmd),
        .i_address(addr), .i_direction_select(dir), .i_ack_select(acks), .i_wdata(wd),
        .o_byte_done(done), .o_busy(busy), .o_outcome(oc), .o_rdata(rd), .o_rd_count(rc),
        .o_wr_count(wc), .i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl), .o_sda_oe(m_sda));
    imbc_slave_model #(.ADDR(SLV)) i_slv (.i_scl(scl), .i_sda(sda), .i_nak(nak),
        .i_stretch(strt), .i_grab_sda(grab), .i_tx(tx), .o_scl_oe(s_scl),
        .o_sda_oe(s_sda), .o_rx(rx), .o_mack(mack));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Notes any pull by the engine, to prove a command left the bus alone
    always @(posedge clk) if (m_sda | m_scl) act = 1'b1;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic issue(input imbc_cmd_t c, input logic [7:0] v);
        @(negedge clk);
        {cmd, dir, acks, wd, cv} = {c, v, v, v, 1'b1};
        @(negedge clk);
        cv = 1'b0;
    endtask : issue
    // A used-up wait bound counts as a mismatch and ends the run
    task automatic limit(input int k);
        if (n >= k) begin
            mismatches++;
            end_of_test();
        end
    endtask : limit
    // Bounded wait for the completion pulse; stretching makes bytes slow
    task automatic await;
        for (n = 0; n < 6000 && done !== 1'b1; n++) @(negedge clk);
        limit(6000);
    endtask : await
    task automatic run(input imbc_cmd_t c, input logic [7:0] v);
        issue(c, v);
        await();
    endtask : run
    task automatic t_write;
        base = wc;
        run(`IMBC_CMD_START, 8'h00);
        chk(oc, `IMBC_OUT_OK);
        chk(rx, {SLV, 1'b0});
        run(`IMBC_CMD_WRITE, 8'hA5);
        chk(rx, 8'hA5);
        chk(wc, base + 8'h01);
        run(`IMBC_CMD_STOP, 8'h00);
        chk(oc, `IMBC_OUT_OK);
    endtask : t_write
    task automatic t_read;
        {strt, base} = {1'b1, rc};
        run(`IMBC_CMD_START, 8'h80);
        chk(rx, {SLV, 1'b1});
        run(`IMBC_CMD_READ, 8'h01);
        chk(rd, tx);
        chk(mack, 1'b0);
        run(`IMBC_CMD_READ, 8'h00);
        chk(mack, 1'b1);
        run(`IMBC_CMD_RESTART, 8'h01);
        chk(oc, `IMBC_OUT_OK);
        run(`IMBC_CMD_READ, 8'h00);
        chk(rd, tx);
        chk(rc, base + 8'h03);
        run(`IMBC_CMD_STOP, 8'h00);
        strt = 1'b0;
    endtask : t_read
    task automatic t_nak;
        run(`IMBC_CMD_START, 8'h00);
        nak = 1'b1;
        run(`IMBC_CMD_WRITE, 8'h3C);
        chk(oc, `IMBC_OUT_NAK);
        nak = 1'b0;
        run(`IMBC_CMD_STOP, 8'h00);
    endtask : t_nak
    task automatic t_clear;
        issue(`IMBC_CMD_CLR_RD, 8'h00);
        issue(`IMBC_CMD_CLR_WR, 8'h00);
        chk(rc, 8'h00);
        chk(wc, 8'h00);
    endtask : t_clear
    task automatic t_fail;
        sact = 1'b1;
        run(`IMBC_CMD_START, 8'h00);
        chk(oc, `IMBC_OUT_NOTOWN);
        {sact, act} = 2'b00;
        run(`IMBC_CMD_WRITE, 8'h5A);
        chk(oc, `IMBC_OUT_NOTOWN);
        run(`IMBC_CMD_READ, 8'h01);
        chk(rd, 8'h00);
        run(`IMBC_CMD_STOP, 8'h00);
        chk(act, 1'b0);
    endtask : t_fail
    task automatic t_busy;
        {grab, act} = 2'b10;
        repeat (4) @(negedge clk);
        run(`IMBC_CMD_START, 8'h00);
        chk(oc, `IMBC_OUT_BUSY);
        chk(act, 1'b0);
        grab = 1'b0;
        // The Stop reaches the busy tracker only through the pin synchroniser
        repeat (4) @(negedge clk);
    endtask : t_busy
    task automatic t_arb;
        {mm, addr} = {1'b1, 7'h7F};
        issue(`IMBC_CMD_START, 8'h00);
        for (n = 0; n < 4000 && !(busy && !scl); n++) @(negedge clk);
        limit(4000);
        grab = 1'b1;
        await();
        chk(oc, `IMBC_OUT_ARB);
        for (n = 0; n < 4000 && !scl; n++) @(negedge clk);
        limit(4000);
        chk(scl, 1'b1);
        {grab, addr} = {1'b0, SLV};
    endtask : t_arb
    task automatic t_abort;
        sen = 1'b1;
        repeat (4) @(negedge clk);
        issue(`IMBC_CMD_START, 8'h00);
        sact = 1'b1;
        await();
        chk(oc, `IMBC_OUT_ABORT);
        {sact, sen, mm} = 3'b000;
    endtask : t_abort
    initial begin
        {mismatches, n_tests} = {32'd0, 32'd0};
        {srst, mm, sen, sact, cv, nak, strt, grab, act} = 9'h100;
        {cmd, addr, dir, acks, wd, tx} = {3'h0, SLV, 24'h000000, 8'hC3};
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_write();
        t_read();
        t_nak();
        t_clear();
        t_fail();
        t_busy();
        t_arb();
        t_abort();
        end_of_test();
    end
endmodule : tb_imbc_master
